// ---- dv/esi_phy_model.sv ----
`timescale 1ns/1ps
module esi_phy_model (
   input wire logic i_clk_sys,
   output logic o_link,
   output logic o_pin_sel,
   output logic o_wake,
   output logic o_carrier
);
   // carrier report kept well past the software recognition period
   localparam int HOLD_CYC = 8;
   initial begin
      o_link = 1'b0;
      o_pin_sel = 1'b0;
      o_wake = 1'b0;
      o_carrier = 1'b0;
   end
   task automatic set_sel(input logic v);
      @(posedge i_clk_sys);
      o_pin_sel <= v;
   endtask
   task automatic flip_link();
      @(posedge i_clk_sys);
      o_link <= ~o_link;
   endtask
   task automatic wake_pulse();
      @(posedge i_clk_sys);
      o_wake <= 1'b1;
      @(posedge i_clk_sys);
      o_wake <= 1'b0;
   endtask
   task automatic carrier_report();
      @(posedge i_clk_sys);
      o_carrier <= 1'b1;
      repeat (HOLD_CYC) @(posedge i_clk_sys);
      o_carrier <= 1'b0;
   endtask
endmodule

// ---- dv/ether_status_irq_logic_bench.sv ----
`timescale 1ns/1ps
module ether_status_irq_logic_bench;
   import esi_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [ESI_ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ESI_DATA_W-1:0] pwdata = '0;
   logic [ESI_DATA_W-1:0] prdata;
   logic pready, pslverr, link, pin_sel, wake, carrier, irq, summary;
   int failures = 0;
   int check_count = 0;
   always #10 clk = ~clk;
   esi_phy_model u_phy (.i_clk_sys(clk), .o_link(link), .o_pin_sel(pin_sel), .o_wake(wake),
      .o_carrier(carrier));
   esi_top u_dut (.i_clk_sys(clk), .i_srst(srst), .i_paddr(paddr), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_link_state_input(link), .i_link_pin_sel(pin_sel), .i_wake_packet_det(wake),
      .i_bad_carrier_det(carrier), .o_irq(irq), .o_controller_event_summary(summary));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic exp_err,
      output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready sampled at the same edge that ends the access; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      chk("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] r;
      xfer(1'b1, a, d, exp_err, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, exp_err, r);
      chk("prdata", exp, r);
   endtask
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk);
      chk("o_irq", {31'h0, exp}, {31'h0, irq});
      chk("summary", {31'h0, exp}, {31'h0, summary});
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      $display("timeout");
      failures++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      rd(ESI_OFS_IRQ_EN, 32'h0, 1'b0);
      rd(12'h008, 32'h0, 1'b1);
      wr(12'h00c, 32'hffffffff, 1'b1);
      $display("test reset done");
      u_phy.wake_pulse();
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h2, 1'b0);
      irq_chk(1'b0);
      wr(ESI_OFS_IRQ_EN, 32'hffffffff, 1'b0);
      rd(ESI_OFS_IRQ_EN, 32'h7, 1'b0);
      irq_chk(1'b1);
      wr(ESI_OFS_FLAGS, 32'hfffffff8, 1'b0);
      rd(ESI_OFS_FLAGS, 32'h2, 1'b0);
      wr(ESI_OFS_FLAGS, 32'h2, 1'b0);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      // a wake packet in the very cycle of its own clear must survive it
      fork
         wr(ESI_OFS_FLAGS, 32'h2, 1'b0);
         begin
            @(posedge clk);
            u_phy.wake_pulse();
         end
      join
      rd(ESI_OFS_FLAGS, 32'h2, 1'b0);
      wr(ESI_OFS_FLAGS, 32'h2, 1'b0);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      irq_chk(1'b0);
      $display("test wake done");
      u_phy.set_sel(1'b1);
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      u_phy.flip_link();
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h4, 1'b0);
      irq_chk(1'b1);
      wr(ESI_OFS_IRQ_EN, 32'h3, 1'b0);
      irq_chk(1'b0);
      wr(ESI_OFS_FLAGS, 32'h4, 1'b0);
      u_phy.flip_link();
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h4, 1'b0);
      wr(ESI_OFS_FLAGS, 32'h4, 1'b0);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      $display("test link done");
      u_phy.carrier_report();
      rd(ESI_OFS_FLAGS, 32'h1, 1'b0);
      irq_chk(1'b1);
      wr(ESI_OFS_IRQ_EN, 32'h6, 1'b0);
      irq_chk(1'b0);
      wr(ESI_OFS_FLAGS, 32'h1, 1'b0);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      // a report still held after its clear must not set the flag again
      fork
         u_phy.carrier_report();
         begin
            repeat (2) @(posedge clk);
            wr(ESI_OFS_FLAGS, 32'h1, 1'b0);
         end
      join
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      $display("test carrier done");
      u_phy.set_sel(1'b0);
      u_phy.flip_link();
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h0, 1'b0);
      u_phy.set_sel(1'b1);
      repeat (2) @(posedge clk);
      rd(ESI_OFS_FLAGS, 32'h4, 1'b0);
      irq_chk(1'b1);
      wr(ESI_OFS_FLAGS, 32'h7, 1'b0);
      irq_chk(1'b0);
      $display("test pin select done");
      stop_test();
   end
endmodule

// ---- include/esi_pkg.sv ----
package esi_pkg;

   localparam int unsigned ESI_DATA_W = 32;
   localparam int unsigned ESI_ADDR_W = 12;
   localparam int unsigned ESI_NUM_FLAGS = 3;
   localparam int unsigned ESI_PAD_W = ESI_DATA_W - ESI_NUM_FLAGS;

   // register byte offsets on the apb bus
   localparam logic [ESI_ADDR_W-1:0] ESI_OFS_FLAGS = 12'h000;
   localparam logic [ESI_ADDR_W-1:0] ESI_OFS_IRQ_EN = 12'h004;

   // bit positions shared by flags and enables
   localparam int unsigned ESI_BIT_LINK = 2;
   localparam int unsigned ESI_BIT_WAKE = 1;
   localparam int unsigned ESI_BIT_CARRIER = 0;

   localparam logic [ESI_NUM_FLAGS-1:0] ESI_FLAGS_RST = 3'h0;
   localparam logic [ESI_NUM_FLAGS-1:0] ESI_IRQ_EN_RST = 3'h0;
   localparam logic [ESI_PAD_W-1:0] ESI_PAD_ZERO = 29'h0;
   localparam logic [ESI_DATA_W-1:0] ESI_RDATA_RST = 32'h0;

   function automatic logic esi_addr_hit(input logic [ESI_ADDR_W-1:0] a);
      return (a == ESI_OFS_FLAGS) || (a == ESI_OFS_IRQ_EN);
   endfunction

endpackage

// ---- include/esi_reg_if.sv ----
`timescale 1ns/1ps
interface esi_reg_if;
   import esi_pkg::*;
   logic wr_stb;
   logic [ESI_ADDR_W-1:0] addr;
   logic [ESI_DATA_W-1:0] wdata;
   logic [ESI_DATA_W-1:0] rdata;
   modport apb (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ---- verilog/esi_apb_slave.sv ----
`timescale 1ns/1ps
module esi_apb_slave import esi_pkg::*; (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [ESI_ADDR_W-1:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ESI_DATA_W-1:0] i_pwdata,
   output logic [ESI_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   esi_reg_if.apb bus
);
   logic [ESI_DATA_W-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [ESI_DATA_W-1:0] nxt_prdata;
   logic nxt_pready;
   logic nxt_pslverr;
   logic setup;
   logic hit;

   // one wait-free access phase: pready rises on the cycle after setup
   always_comb begin
      setup = i_psel & ~i_penable;
      hit = esi_addr_hit(i_paddr);
      nxt_pready = setup;
      nxt_pslverr = setup ? ~hit : 1'b0;
      nxt_prdata = prdata_ff;
      if (setup && !i_pwrite) begin
         nxt_prdata = hit ? bus.rdata : ESI_RDATA_RST;
      end
      bus.addr = i_paddr;
      bus.wdata = i_pwdata;
      bus.wr_stb = i_psel & i_penable & pready_ff & i_pwrite & hit;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prdata_ff <= ESI_RDATA_RST;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
endmodule

// ---- verilog/esi_edge_det.sv ----
`timescale 1ns/1ps
module esi_edge_det import esi_pkg::*; (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_level,
   input wire logic i_arm,
   output logic o_rise,
   output logic o_fall
);
   logic prev_ff;
   logic nxt_prev;

   // history is held low while disarmed, so arming with a high level reports a rise
   always_comb begin
      nxt_prev = i_arm ? i_level : 1'b0;
      o_rise = i_arm & i_level & ~prev_ff;
      o_fall = i_arm & ~i_level & prev_ff;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
      end
   end
endmodule

// ---- verilog/esi_top.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module esi_top import esi_pkg::*; (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [ESI_ADDR_W-1:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ESI_DATA_W-1:0] i_pwdata,
   output logic [ESI_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_link_state_input,
   input wire logic i_link_pin_sel,
   input wire logic i_wake_packet_det,
   input wire logic i_bad_carrier_det,
   output logic o_irq,
   output logic o_controller_event_summary
);

   esi_reg_if u_reg_if ();

   esi_apb_slave u_apb (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_paddr(i_paddr),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .bus(u_reg_if.apb)
   );

   logic link_rise;
   logic link_fall;
   logic carrier_rise;

   // the link detector is armed only while the pin carries the link function
   esi_edge_det u_link_det (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_level(i_link_state_input),
      .i_arm(i_link_pin_sel),
      .o_rise(link_rise),
      .o_fall(link_fall)
   );

   // carrier report counts once per rising edge, so a clear is not undone
   // at once by a report that is still held high
   esi_edge_det u_carrier_det (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_level(i_bad_carrier_det),
      .i_arm(1'b1),
      .o_rise(carrier_rise),
      .o_fall()
   );

   logic [ESI_NUM_FLAGS-1:0] flags_ff;
   logic [ESI_NUM_FLAGS-1:0] irq_en_ff;
   logic irq_ff;
   logic summary_ff;
   logic [ESI_NUM_FLAGS-1:0] nxt_flags;
   logic [ESI_NUM_FLAGS-1:0] nxt_irq_en;
   logic nxt_irq;
   logic [ESI_NUM_FLAGS-1:0] set_vec;
   logic [ESI_NUM_FLAGS-1:0] gated;
   logic wr_flags;
   logic wr_irq_en;

   always_comb begin
      wr_flags = u_reg_if.wr_stb && (u_reg_if.addr == ESI_OFS_FLAGS);
      wr_irq_en = u_reg_if.wr_stb && (u_reg_if.addr == ESI_OFS_IRQ_EN);
      set_vec = '0;
      set_vec[ESI_BIT_LINK] = link_rise | link_fall;
      set_vec[ESI_BIT_WAKE] = i_wake_packet_det;
      set_vec[ESI_BIT_CARRIER] = carrier_rise;
      nxt_flags = flags_ff;
      nxt_irq_en = irq_en_ff;
      if (wr_flags) begin
         nxt_flags = flags_ff & ~u_reg_if.wdata[ESI_NUM_FLAGS-1:0];
      end
      if (wr_irq_en) begin
         nxt_irq_en = u_reg_if.wdata[ESI_NUM_FLAGS-1:0];
      end
      // an event in the clearing cycle survives
      nxt_flags = nxt_flags | set_vec;
      gated = nxt_flags & nxt_irq_en;
      nxt_irq = |gated;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         flags_ff <= ESI_FLAGS_RST;
         irq_en_ff <= ESI_IRQ_EN_RST;
         irq_ff <= 1'b0;
         summary_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         irq_en_ff <= nxt_irq_en;
         irq_ff <= nxt_irq;
         summary_ff <= nxt_irq;
      end
   end

   // upper bits are tied off so they always read zero
   always_comb begin
      unique case (u_reg_if.addr)
         ESI_OFS_FLAGS: u_reg_if.rdata = {ESI_PAD_ZERO, flags_ff};
         ESI_OFS_IRQ_EN: u_reg_if.rdata = {ESI_PAD_ZERO, irq_en_ff};
         default: u_reg_if.rdata = ESI_RDATA_RST;
      endcase
   end

   assign o_irq = irq_ff;
   assign o_controller_event_summary = summary_ff;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   // helper: access edge of a write to each register
   logic acc_wr_flags;
   logic acc_wr_en;
   assign acc_wr_flags = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == ESI_OFS_FLAGS);
   assign acc_wr_en = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == ESI_OFS_IRQ_EN);

   sequence s_link_toggle;
      i_link_pin_sel && $past(i_link_pin_sel) && (i_link_state_input != $past(i_link_state_input));
   endsequence

   sequence s_pin_select_high;
      $rose(i_link_pin_sel) && i_link_state_input;
   endsequence

   sequence s_apb_read(logic [ESI_ADDR_W-1:0] a);
      i_psel && !i_penable && !i_pwrite && (i_paddr == a) ##1 i_psel && i_penable && o_pready;
   endsequence

   a_link_edge_set: assert property (
      s_link_toggle |=> flags_ff[ESI_BIT_LINK]
   ) else $error("link edge did not set link flag");

   a_pin_select_flag: assert property (
      s_pin_select_high |=> flags_ff[ESI_BIT_LINK]
   ) else $error("pin select with link high did not flag");

   a_wake_set: assert property (
      i_wake_packet_det |=> flags_ff[ESI_BIT_WAKE]
   ) else $error("wake packet did not set wake flag");

   a_carrier_set: assert property (
      $rose(i_bad_carrier_det) |=> flags_ff[ESI_BIT_CARRIER]
   ) else $error("carrier report did not set carrier flag");

   a_one_clears_flag: assert property (
      acc_wr_flags && i_pwdata[ESI_BIT_WAKE] && !i_wake_packet_det |=> !flags_ff[ESI_BIT_WAKE]
   ) else $error("write one did not clear wake flag");

   a_zero_keeps_flag: assert property (
      acc_wr_flags && !i_pwdata[ESI_BIT_CARRIER] && flags_ff[ESI_BIT_CARRIER]
         |=> flags_ff[ESI_BIT_CARRIER]
   ) else $error("write zero changed carrier flag");

   a_flags_stable_idle: assert property (
      !u_reg_if.wr_stb && !i_wake_packet_det && flags_ff[ESI_BIT_WAKE] |=> flags_ff[ESI_BIT_WAKE]
   ) else $error("wake flag dropped without a clear");

   a_reserved_read_zero: assert property (
      s_apb_read(ESI_OFS_FLAGS) or s_apb_read(ESI_OFS_IRQ_EN) |-> o_prdata[ESI_DATA_W-1:ESI_NUM_FLAGS] == '0
   ) else $error("reserved status bits read nonzero");

   a_gate_link: assert property (
      flags_ff[ESI_BIT_LINK] && irq_en_ff[ESI_BIT_LINK] |-> o_irq
   ) else $error("enabled link flag raised no interrupt");

   a_gate_wake: assert property (
      flags_ff[ESI_BIT_WAKE] && irq_en_ff[ESI_BIT_WAKE] |-> o_irq
   ) else $error("enabled wake flag raised no interrupt");

   a_gate_carrier: assert property (
      flags_ff[ESI_BIT_CARRIER] && irq_en_ff[ESI_BIT_CARRIER] |-> o_irq
   ) else $error("enabled carrier flag raised no interrupt");

   a_masked_quiet: assert property (
      (flags_ff & irq_en_ff) == '0 |-> !o_irq
   ) else $error("interrupt high with nothing enabled pending");

   a_irq_or_gated: assert property (
      o_irq == |(flags_ff & irq_en_ff)
   ) else $error("interrupt differs from gated flag or");

   a_summary_follow: assert property (
      o_controller_event_summary == o_irq
   ) else $error("event summary differs from interrupt");

   a_enable_write: assert property (
      acc_wr_en |=> irq_en_ff == $past(i_pwdata[ESI_NUM_FLAGS-1:0])
   ) else $error("enable register did not take write");

   // flags only fall through a write of one; events can only raise them
   logic acc_wr_any;
   assign acc_wr_any = i_psel & i_penable & o_pready & i_pwrite;

   a_link_clear: assert property (
      acc_wr_flags && i_pwdata[ESI_BIT_LINK] && !link_rise && !link_fall |=> !flags_ff[ESI_BIT_LINK]
   ) else $error("write one did not clear link flag");

   a_carrier_clear: assert property (
      acc_wr_flags && i_pwdata[ESI_BIT_CARRIER] && !carrier_rise |=> !flags_ff[ESI_BIT_CARRIER]
   ) else $error("write one did not clear carrier flag");

   a_wake_set_wins: assert property (
      acc_wr_flags && i_pwdata[ESI_BIT_WAKE] && i_wake_packet_det |=> flags_ff[ESI_BIT_WAKE]
   ) else $error("clear beat a wake packet in the same cycle");

   a_zero_keeps_link: assert property (
      acc_wr_flags && !i_pwdata[ESI_BIT_LINK] && flags_ff[ESI_BIT_LINK] |=> flags_ff[ESI_BIT_LINK]
   ) else $error("write zero changed link flag");

   a_zero_keeps_wake: assert property (
      acc_wr_flags && !i_pwdata[ESI_BIT_WAKE] && flags_ff[ESI_BIT_WAKE] |=> flags_ff[ESI_BIT_WAKE]
   ) else $error("write zero changed wake flag");

   a_link_stable_idle: assert property (
      !acc_wr_any && flags_ff[ESI_BIT_LINK] |=> flags_ff[ESI_BIT_LINK]
   ) else $error("link flag dropped without a clear");

   a_carrier_stable_idle: assert property (
      !acc_wr_any && flags_ff[ESI_BIT_CARRIER] |=> flags_ff[ESI_BIT_CARRIER]
   ) else $error("carrier flag dropped without a clear");

   a_link_quiet_unsel: assert property (
      !i_link_pin_sel && !flags_ff[ESI_BIT_LINK] |=> !flags_ff[ESI_BIT_LINK]
   ) else $error("link flag set while pin not selected");

   a_link_fall_set: assert property (
      !$past(i_srst) && i_link_pin_sel && $past(i_link_pin_sel) && $fell(i_link_state_input)
         |=> flags_ff[ESI_BIT_LINK]
   ) else $error("falling link level did not set link flag");

   a_pin_select_low: assert property (
      $rose(i_link_pin_sel) && !i_link_state_input && !flags_ff[ESI_BIT_LINK]
         |=> !flags_ff[ESI_BIT_LINK]
   ) else $error("pin select with link low raised link flag");

   a_wake_quiet: assert property (
      !i_wake_packet_det && !flags_ff[ESI_BIT_WAKE] |=> !flags_ff[ESI_BIT_WAKE]
   ) else $error("wake flag set with no wake packet");

   a_carrier_quiet: assert property (
      !i_bad_carrier_det && !flags_ff[ESI_BIT_CARRIER] |=> !flags_ff[ESI_BIT_CARRIER]
   ) else $error("carrier flag set with no carrier report");

   a_carrier_held_once: assert property (
      acc_wr_flags && i_pwdata[ESI_BIT_CARRIER] && i_bad_carrier_det && $past(i_bad_carrier_det)
         |=> !flags_ff[ESI_BIT_CARRIER]
   ) else $error("held carrier report set the flag again");

   a_enable_hold: assert property (
      !acc_wr_en |=> $stable(irq_en_ff)
   ) else $error("enable register changed without a write");

   a_miss_write_ignored: assert property (
      acc_wr_any && !esi_addr_hit(i_paddr) |=> $stable(irq_en_ff)
   ) else $error("unmapped write changed enable register");

   a_wake_gate_rise: assert property (
      flags_ff[ESI_BIT_WAKE] && acc_wr_en && i_pwdata[ESI_BIT_WAKE] |=> o_irq
   ) else $error("enabling a pending wake flag raised no interrupt");

   a_irq_hold: assert property (
      o_irq && !acc_wr_any |=> o_irq
   ) else $error("interrupt dropped with no register write");

   a_summary_rise: assert property (
      $rose(o_irq) |-> $rose(o_controller_event_summary)
   ) else $error("event summary did not rise with interrupt");

   // read word is built from the register state of the setup cycle
   a_read_flags_word: assert property (
      s_apb_read(ESI_OFS_FLAGS) |-> o_prdata == {ESI_PAD_ZERO, $past(flags_ff)}
   ) else $error("flag read word differs from flag state");

   a_read_en_word: assert property (
      s_apb_read(ESI_OFS_IRQ_EN) |-> o_prdata == {ESI_PAD_ZERO, $past(irq_en_ff)}
   ) else $error("enable read word differs from enable state");

endmodule
